// >>> common/tmr16_consts.vh
`ifndef TMR16_CONSTS_VH
`define TMR16_CONSTS_VH
// register indices; byte address is four times the index
`define TMR16_IDX_PDIR 16'hff22
`define TMR16_IDX_PASEL 16'hff23
`define TMR16_IDX_PRESC 16'hff24
`define TMR16_IDX_MODE 16'hff25
`define TMR16_IDX_CCCTL 16'hff26
`define TMR16_IDX_CNT 16'hff27
`define TMR16_IDX_CCA 16'hff28
`define TMR16_IDX_CCB 16'hff29
`define TMR16_IDX_STAT 16'hff2a
`define TMR16_PDIR_RST 8'hff
`define TMR16_PASEL_RST 8'h00
`define TMR16_PDIR_FIXED 4'hf
// mode field of timer_mode_control
`define TMR16_MODE_STOP 2'b00
`define TMR16_MODE_FREE 2'b01
`define TMR16_MODE_CLEAR 2'b10
// clock select codes
`define TMR16_CK_FULL 2'b00
`define TMR16_CK_DIV4 2'b01
`define TMR16_CK_DIV256 2'b10
`define TMR16_CK_EVENT 2'b11
// edge select codes
`define TMR16_ES_FALL 2'b00
`define TMR16_ES_RISE 2'b01
`define TMR16_ES_BOTH 2'b11
// field positions
`define TMR16_CC_CAPA 0
`define TMR16_CC_SRC 1
`define TMR16_CC_CAPB 2
`define TMR16_ST_OVF 0
`define TMR16_ST_MATCHA 1
`define TMR16_ST_CAPB 2
`define TMR16_CNT_MAX 16'hffff
`define TMR16_DIV4_LAST 2'h3
`define TMR16_DIV256_LAST 8'hff
`endif

// >>> core/tmr16_top.v
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "tmr16_consts.vh"
module tmr16_top (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [17:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire event_input_a_i,
    input wire capture_input_b_i,
    output reg [7:0] port_direction_o,
    output reg [7:0] port_analog_select_o,
    output reg match_a_irq_o,
    output reg capture_b_irq_o,
    output reg overflow_o
);

////////////////////////////////////////////////////////////////////////////////
// helpers

// edge qualification shared by both inputs
function valid_edge;
    input [1:0] es;
    input rose;
    input fell;
    begin
        if (es == `TMR16_ES_FALL) begin
            valid_edge = fell;
        end else if (es == `TMR16_ES_RISE) begin
            valid_edge = rose;
        end else if (es == `TMR16_ES_BOTH) begin
            valid_edge = rose | fell;
        end else begin
            valid_edge = 1'b0;
        end
    end
endfunction

// sticky flag update: an event in the same cycle as a clear keeps the flag set
function sticky_next;
    input cur;
    input set;
    input clr;
    begin
        if (set) begin
            sticky_next = 1'b1;
        end else if (clr) begin
            sticky_next = 1'b0;
        end else begin
            sticky_next = cur;
        end
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// registers

// software-visible state; counter and compare B are read-only from the bus
reg [7:0] presc; // es_b[7:6], es_a[5:4], clksel[1:0]
reg [1:0] mode;
reg [2:0] ccctl;
reg [15:0] cnt;
reg [15:0] cca;
reg [15:0] ccb;
reg [2:0] stat;
reg [7:0] div;

// bus decode; only the cycle in which ack stands may write
wire [15:0] idx = wb_adr_i[17:2];
wire req = wb_cyc_i & wb_stb_i;
wire wr = req & wb_we_i & wb_ack_o; // write lands on the edge the master sees ack
wire running = (mode != `TMR16_MODE_STOP);
// prescaler mode fields
wire [1:0] clksel = presc[1:0];
wire [1:0] es_a = presc[5:4];
wire [1:0] es_b = presc[7:6];

////////////////////////////////////////////////////////////////////////////////
// input synchronisers and noise filters

// two flops per pin, then a two-sample level filter
reg [1:0] a_sync;
reg [1:0] b_sync;
reg a_smp;
reg a_lvl;
reg b_smp;
reg b_lvl;
reg presc_tick;

// divider free-runs so the first tick is never late by more than one period
always @(posedge clk_i) begin
    if (rst_i) begin
        div <= 8'h00;
    end else begin
        div <= div + 8'h01;
    end
end

// selected prescaler tick, one cycle wide
always @* begin
    if (clksel == `TMR16_CK_FULL) begin
        presc_tick = 1'b1;
    end else if (clksel == `TMR16_CK_DIV4) begin
        presc_tick = (div[1:0] == `TMR16_DIV4_LAST);
    end else if (clksel == `TMR16_CK_DIV256) begin
        presc_tick = (div == `TMR16_DIV256_LAST);
    end else begin
        presc_tick = 1'b1;
    end
end

// event counting samples at clk, capture at the count clock
wire smp_en = (clksel == `TMR16_CK_EVENT) ? 1'b1 : presc_tick;

// nothing reads the first flop except the second, so metastability stays contained
always @(posedge clk_i) begin
    if (rst_i) begin
        a_sync <= 2'b00;
        b_sync <= 2'b00;
    end else begin
        a_sync <= {a_sync[0], event_input_a_i};
        b_sync <= {b_sync[0], capture_input_b_i};
    end
end

// a level is accepted only when two successive samples agree
always @(posedge clk_i) begin
    if (rst_i) begin
        a_smp <= 1'b0;
        a_lvl <= 1'b0;
        b_smp <= 1'b0;
        b_lvl <= 1'b0;
    end else if (smp_en) begin
        a_smp <= a_sync[1];
        b_smp <= b_sync[1];
        if (a_sync[1] == a_smp) begin
            a_lvl <= a_smp;
        end
        if (b_sync[1] == b_smp) begin
            b_lvl <= b_smp;
        end
    end
end

// edges are taken against the last accepted level, which is tracked even while stopped
wire a_acc = smp_en & (a_sync[1] == a_smp);
wire b_acc = smp_en & (b_sync[1] == b_smp);
wire a_rose = a_acc & a_smp & ~a_lvl;
wire a_fell = a_acc & ~a_smp & a_lvl;
wire b_rose = b_acc & b_smp & ~b_lvl;
wire b_fell = b_acc & ~b_smp & b_lvl;

// qualified edges; the reversed copy feeds the event-A sourced capture
wire edge_a = valid_edge(es_a, a_rose, a_fell);
wire edge_b = valid_edge(es_b, b_rose, b_fell);
wire edge_a_rev = valid_edge(es_a, a_fell, a_rose);

////////////////////////////////////////////////////////////////////////////////
// counter, compare and capture

// count source chosen by clksel
wire count_ev = running & ((clksel == `TMR16_CK_EVENT) ? edge_a : presc_tick);
wire clear_mode = (mode == `TMR16_MODE_CLEAR);
// match and overflow only fire on a real count step
wire hit_a = count_ev & clear_mode & (cnt == cca);
wire at_max = (cnt == `TMR16_CNT_MAX);
// a-capture: src 0 from capture B edge, src 1 from the opposite event A edge
wire a_trig = ccctl[`TMR16_CC_SRC] ? (edge_a_rev & (es_a != `TMR16_ES_BOTH)) : edge_b;
wire cap_a = running & ccctl[`TMR16_CC_CAPA] & ~clear_mode & a_trig;
wire cap_b = running & ccctl[`TMR16_CC_CAPB] & edge_a;
wire ovf_ev = count_ev & at_max & (~clear_mode | (cca == `TMR16_CNT_MAX));
// write-one-to-clear strobes for the status bits
wire [2:0] stat_clr = (wr && idx == `TMR16_IDX_STAT && wb_sel_i[0]) ? wb_dat_i[2:0] : 3'b000;

// stopped counter is held at zero so each start begins from 0000H
always @(posedge clk_i) begin
    if (rst_i) begin
        cnt <= 16'h0000;
    end else if (!running) begin
        cnt <= 16'h0000;
    end else if (hit_a) begin
        cnt <= 16'h0000;
    end else if (count_ev) begin
        cnt <= cnt + 16'h0001; // wraps past a lowered compare
    end
end

// captures take the count as it stands before this edge's increment
always @(posedge clk_i) begin
    if (rst_i) begin
        cca <= 16'h0000;
        ccb <= 16'h0000;
    end else begin
        if (cap_a) begin
            cca <= cnt;
        end else if (wr && idx == `TMR16_IDX_CCA) begin
            if (wb_sel_i[0]) begin
                cca[7:0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
                cca[15:8] <= wb_dat_i[15:8];
            end
        end
        if (cap_b) begin
            ccb <= cnt;
        end
    end
end

// event pulses and sticky status; a new event beats a same-cycle clear
always @(posedge clk_i) begin
    if (rst_i) begin
        match_a_irq_o <= 1'b0;
        capture_b_irq_o <= 1'b0;
        overflow_o <= 1'b0;
        stat <= 3'b000;
    end else begin
        match_a_irq_o <= hit_a | cap_a;
        capture_b_irq_o <= cap_b;
        stat[`TMR16_ST_OVF] <= sticky_next(stat[`TMR16_ST_OVF], ovf_ev, stat_clr[`TMR16_ST_OVF]);
        stat[`TMR16_ST_MATCHA] <= sticky_next(stat[`TMR16_ST_MATCHA], hit_a | cap_a, stat_clr[`TMR16_ST_MATCHA]);
        stat[`TMR16_ST_CAPB] <= sticky_next(stat[`TMR16_ST_CAPB], cap_b, stat_clr[`TMR16_ST_CAPB]);
        // the pin follows the flag's next value, so both agree from the same edge on
        overflow_o <= sticky_next(stat[`TMR16_ST_OVF], ovf_ev, stat_clr[`TMR16_ST_OVF]);
    end
end

////////////////////////////////////////////////////////////////////////////////
// control and port registers

// settings are written while stopped; the block does not enforce that
always @(posedge clk_i) begin
    if (rst_i) begin
        presc <= 8'h00;
        mode <= `TMR16_MODE_STOP;
        ccctl <= 3'b000;
        port_direction_o <= `TMR16_PDIR_RST;
        port_analog_select_o <= `TMR16_PASEL_RST;
    end else if (wr && wb_sel_i[0]) begin
        // every 8-bit register sits on byte lane 0
        if (idx == `TMR16_IDX_PRESC) begin
            presc <= {wb_dat_i[7:4], 2'b00, wb_dat_i[1:0]};
        end else if (idx == `TMR16_IDX_MODE) begin
            mode <= wb_dat_i[1:0];
        end else if (idx == `TMR16_IDX_CCCTL) begin
            ccctl <= wb_dat_i[2:0];
        end else if (idx == `TMR16_IDX_PDIR) begin
            port_direction_o <= {`TMR16_PDIR_FIXED, wb_dat_i[3:0]}; // 0 drives, 1 floats
        end else if (idx == `TMR16_IDX_PASEL) begin
            port_analog_select_o <= wb_dat_i[7:0]; // 1 hands the pin to the converter
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// wishbone slave: one wait state, ack for every address

// read mux; unmapped indices read zero rather than a stale value
reg [15:0] rd_val;

always @* begin
    if (idx == `TMR16_IDX_PDIR) begin
        rd_val = {8'h00, port_direction_o};
    end else if (idx == `TMR16_IDX_PASEL) begin
        rd_val = {8'h00, port_analog_select_o};
    end else if (idx == `TMR16_IDX_PRESC) begin
        rd_val = {8'h00, presc};
    end else if (idx == `TMR16_IDX_MODE) begin
        rd_val = {14'h0000, mode};
    end else if (idx == `TMR16_IDX_CCCTL) begin
        rd_val = {13'h0000, ccctl};
    end else if (idx == `TMR16_IDX_CNT) begin
        rd_val = cnt;
    end else if (idx == `TMR16_IDX_CCA) begin
        rd_val = cca;
    end else if (idx == `TMR16_IDX_CCB) begin
        rd_val = ccb;
    end else if (idx == `TMR16_IDX_STAT) begin
        rd_val = {13'h0000, stat};
    end else begin
        rd_val = 16'h0000; // unmapped reads zero
    end
end

// ack drops after one cycle even if the master keeps its request up
always @(posedge clk_i) begin
    if (rst_i) begin
        wb_ack_o <= 1'b0;
        wb_dat_o <= 32'h0000_0000;
    end else begin
        wb_ack_o <= req & ~wb_ack_o;
        wb_dat_o <= {16'h0000, rd_val};
    end
end

endmodule
`default_nettype wire

// >>> tb/tmr16_chk_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module tmr16_chk (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [17:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [7:0] port_direction_o,
    input wire logic [7:0] port_analog_select_o,
    input wire logic match_a_irq_o,
    input wire logic capture_b_irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////////////
    // an acked low-byte write to one register index
    sequence wr_s(idx);
        wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0] && wb_adr_i[17:2] == idx;
    endsequence
    // plain flags for the hold checks, since a sequence cannot be negated cheaply
    wire wr_dir = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i[17:2] == 16'hff22;
    wire wr_asel = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i[17:2] == 16'hff23;
    ////////////////////////////////////////////////////////////////////////
    pdir_fixed_a: assert property (port_direction_o[7:4] == 4'hf)
        else $error("direction upper nibble not all ones");
    reset_value_a: assert property ($past(rst_i) |-> port_direction_o == 8'hff && port_analog_select_o == 8'h00)
        else $error("port registers wrong after reset");
    pdir_write_a: assert property (wr_s(16'hff22) |=> port_direction_o == {4'hf, $past(wb_dat_i[3:0])})
        else $error("direction write not applied");
    asel_write_a: assert property (wr_s(16'hff23) |=> port_analog_select_o == $past(wb_dat_i[7:0]))
        else $error("analog select write not applied");
    pdir_read_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i[17:2] == 16'hff22 |-> wb_dat_o == {24'h0, port_direction_o})
        else $error("direction readback mismatch");
    pdir_hold_a: assert property (!wr_dir |=> $stable(port_direction_o))
        else $error("direction changed without a write");
    asel_hold_a: assert property (!wr_asel |=> $stable(port_analog_select_o))
        else $error("analog select changed without a write");
    irq_pulse_a: assert property ((match_a_irq_o || capture_b_irq_o) |=> !match_a_irq_o && !capture_b_irq_o)
        else $error("request pulse longer than one cycle");
endmodule
`default_nettype wire

// >>> tb/tmr16_pulse_src.sv
`timescale 1ns/1ns
`default_nettype none
module tmr16_pulse_src (
    input wire logic clk_i,
    output logic event_a_o,
    output logic capture_b_o
);
    // both pins idle low
    initial begin
        event_a_o = 1'b0;
        capture_b_o = 1'b0;
    end
    // a pulse of w clocks; short ones exist only to probe the noise filter
    task pulse(input logic pin, input int w);
        begin
            @(posedge clk_i);
            if (pin) capture_b_o <= 1'b1; else event_a_o <= 1'b1;
            repeat (w) @(posedge clk_i);
            if (pin) capture_b_o <= 1'b0; else event_a_o <= 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// >>> tb/timer16_interval_event_capture_tb.sv
`timescale 1ns/1ns
`default_nettype none
module timer16_interval_event_capture_tb;
    logic clk_i, rst_i, cyc, stb, we, ev_a, cap_b, wb_ack_o, match_a_irq_o, capture_b_irq_o, overflow_o;
    logic [17:0] adr;
    logic [31:0] dat, rd, v1, wb_dat_o;
    logic [7:0] port_direction_o, port_analog_select_o;
    int num_errors, n_compared, cycles, n_match, n_capb, g, n;
    int per [3] = '{6, 24, 1536};
    logic [1:0] codes [5] = '{2'b00, 2'b01, 2'b10, 2'b11, 2'b01};
    int widths [5] = '{6, 6, 6, 6, 1};
    logic [31:0] incs [5] = '{0: 1, 1: 1, 2: 0, 3: 2, 4: 0};
    tmr16_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'h3), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .event_input_a_i(ev_a),
        .capture_input_b_i(cap_b), .port_direction_o(port_direction_o), .port_analog_select_o(port_analog_select_o),
        .match_a_irq_o(match_a_irq_o), .capture_b_irq_o(capture_b_irq_o), .overflow_o(overflow_o));
    tmr16_pulse_src src_u (.clk_i(clk_i), .event_a_o(ev_a), .capture_b_o(cap_b));
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        begin
            n_compared++;
            if (seen !== exp) begin
                num_errors++;
                $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    // one classic cycle, held until ack is sampled high
    task xfer(input logic w, input logic [15:0] idx, input logic [31:0] d);
        begin
            @(posedge clk_i);
            cyc <= 1'b1;
            stb <= 1'b1;
            we <= w;
            adr <= {idx, 2'b00};
            dat <= d;
            @(posedge clk_i);
            while (wb_ack_o !== 1'b1) @(posedge clk_i);
            rd = wb_dat_o;
            cyc <= 1'b0;
            stb <= 1'b0;
        end
    endtask
    // clocks from one compare-A pulse to the next
    task gap(output int p);
        begin
            p = 0;
            while (match_a_irq_o !== 1'b1) @(posedge clk_i);
            do begin
                @(posedge clk_i);
                p++;
            end while (match_a_irq_o !== 1'b1);
        end
    endtask
    task print_verdict;
        begin
            $display("errors=%0d compared=%0d", num_errors, n_compared);
            if (num_errors == 0 && n_compared > 0) $display("[ PASS ]");
            else $display("[ FAIL ]");
            $finish;
        end
    endtask
    // pulse counters and a ceiling well above the long overflow wait
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (match_a_irq_o === 1'b1) n_match <= n_match + 1;
        if (capture_b_irq_o === 1'b1) n_capb <= n_capb + 1;
        if (cycles == 95000) begin
            num_errors++;
            print_verdict();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {rst_i, cyc, stb, we, adr, dat} = {1'b1, 53'h0};
        {num_errors, n_compared, cycles, n_match, n_capb} = '0;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        xfer(0, 16'hff22, 0);
        check(rd, 32'h0000_00ff);
        xfer(0, 16'hff23, 0);
        check(rd, 32'h0000_0000);
        xfer(1, 16'hff22, 32'h0000_0000);
        xfer(0, 16'hff22, 0);
        check(rd, 32'h0000_00f0);
        xfer(1, 16'hff23, 32'h0000_000f);
        xfer(0, 16'hff23, 0);
        check(rd, 32'h0000_000f);
        xfer(1, 16'hff23, 32'h0000_0000);
        xfer(1, 16'hff22, 32'h0000_0003);
        xfer(0, 16'hff22, 0);
        check(rd, 32'h0000_00f3);
        xfer(0, 16'hff30, 0);
        check(rd, 32'h0000_0000);
        // interval period at the full, divide-by-4 and divide-by-256 clocks
        for (g = 0; g < 3; g++) begin
            xfer(1, 16'hff25, 0);
            xfer(1, 16'hff24, g);
            xfer(1, 16'hff28, 32'h0000_0005);
            xfer(1, 16'hff25, 32'h0000_0002);
            gap(n);
            check(n, per[g]);
        end
        check({31'h0, overflow_o}, 0);
        // compare A lowered below the running count: no clear, counting goes on
        xfer(1, 16'hff25, 0);
        xfer(1, 16'hff24, 0);
        xfer(1, 16'hff28, 32'h0000_0100);
        xfer(1, 16'hff25, 32'h0000_0002);
        repeat (100) @(posedge clk_i);
        g = n_match;
        xfer(1, 16'hff28, 32'h0000_0010);
        repeat (20) @(posedge clk_i);
        xfer(0, 16'hff27, 0);
        check({31'h0, rd > 32'h0000_0040}, 32'h1);
        check(n_match - g, 0);
        xfer(1, 16'hff25, 0);
        xfer(1, 16'hff25, 32'h0000_0002);
        gap(n);
        check(n, 17);
        // event counting per edge code, last entry is a glitch
        xfer(1, 16'hff28, 32'h0000_ffff);
        for (g = 0; g < 5; g++) begin
            xfer(1, 16'hff25, 0);
            xfer(1, 16'hff24, {24'h0, 2'b00, codes[g], 4'h3});
            xfer(1, 16'hff25, 32'h0000_0002);
            src_u.pulse(0, widths[g]);
            repeat (12) @(posedge clk_i);
            xfer(0, 16'hff27, 0);
            check(rd, incs[g]);
        end
        xfer(1, 16'hff25, 0);
        xfer(1, 16'hff28, 32'h0000_0002);
        xfer(1, 16'hff25, 32'h0000_0002);
        g = n_match;
        repeat (3) begin
            src_u.pulse(0, 6);
            repeat (6) @(posedge clk_i);
        end
        xfer(0, 16'hff27, 0);
        check(rd, 0);
        check(n_match - g, 1);
        // free-running width capture on both pins, both edges
        xfer(1, 16'hff25, 0);
        xfer(1, 16'hff24, 32'h0000_00f0);
        xfer(1, 16'hff26, 32'h0000_0005);
        xfer(1, 16'hff25, 32'h0000_0001);
        g = n_capb;
        fork
            src_u.pulse(0, 20);
        join_none
        repeat (10) @(posedge clk_i);
        xfer(0, 16'hff29, 0);
        v1 = rd;
        repeat (20) @(posedge clk_i);
        xfer(0, 16'hff29, 0);
        check(rd - v1, 20);
        check(n_capb - g, 2);
        g = n_match;
        fork
            src_u.pulse(1, 30);
        join_none
        repeat (10) @(posedge clk_i);
        xfer(0, 16'hff28, 0);
        v1 = rd;
        repeat (30) @(posedge clk_i);
        xfer(0, 16'hff28, 0);
        check(rd - v1, 30);
        check(n_match - g, 2);
        // event-A sourced capture is blocked while A takes both edges
        xfer(1, 16'hff26, 32'h0000_0007);
        src_u.pulse(0, 8);
        repeat (12) @(posedge clk_i);
        xfer(0, 16'hff28, 0);
        check(rd, v1 + 32'd30);
        while (overflow_o !== 1'b1) @(posedge clk_i);
        xfer(0, 16'hff2a, 0);
        check(rd & 32'h1, 32'h1);
        xfer(1, 16'hff2a, 32'h0000_0001);
        xfer(0, 16'hff2a, 0);
        check(rd & 32'h1, 32'h0);
        print_verdict();
    end
endmodule
bind tmr16_top tmr16_chk chk_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .port_direction_o(port_direction_o), .port_analog_select_o(port_analog_select_o),
    .match_a_irq_o(match_a_irq_o), .capture_b_irq_o(capture_b_irq_o));
`default_nettype wire
